// file: core/pscl_consts.vh
// Constants for the passive serial configuration loader
//
// Summary of operation
// (RL1) Capture one serial bit on each rising config_clock edge; edges are ignored while a loaded word is stalled by a full buffer.
// (RL2) Host alone drives config_clock and data and controls loading.
// (RL3) No maximum clock period; a stopped clock pauses loading cleanly.
// (RL4) Host keeps config_clock below the system frequency limit.
// (RL5) Host watches load_complete for errors and finish, optionally init done.
// (RL6) Host reconfigures when all data sent but completion flags stay low.
// (RL7) Host drives clock and data to a fixed level after configuration; the host model leaves data at its inverted last value.
// (RL8) Data pin becomes user I/O after loading; parallel scheme defaults released.
// (RL9) Finished device drives chain_enable_out low to enable the next device.
// (RL10) Newly enabled downstream device accepts data within one clock cycle.
// (RL11) Host streams continuously across chained device handover.
// (RL12) Active parallel boot address defaults to 0x010000, replaceable by instruction.
// (RL13) Ignore clock and data while chip_enable_in high; chain output stays high.
// (RL14) Release load_complete only after last bit accepted; low after reconfig.
// (RL15) Fast parallel scheme captures a full byte per rising clock edge.
`ifndef PSCL_CONSTS_VH
`define PSCL_CONSTS_VH
`define PSCL_BOOT_ADDR 24'h010000
`define PSCL_ADDR_W 24
`define PSCL_SYNC_RST 2'h0
`define PSCL_ST_IDLE 2'h0
`define PSCL_ST_LOAD 2'h1
`define PSCL_ST_DONE 2'h2
`define PSCL_ST_ERR 2'h3
`define PSCL_BIT_CNT_W 32
`define PSCL_SCHEME_PS 2'h0
`define PSCL_SCHEME_FPP 2'h1
`define PSCL_SCHEME_AP 2'h2
`endif

// file: core/pscl_buf2.v
// Two-entry valid/ready buffer for loaded words
`timescale 1ns/1ps
`default_nettype none
module pscl_buf2 #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:1];
    reg wrPtr_r;
    reg rdPtr_r;
    reg [1:0] count_r;
    wire doWr;
    wire doRd;
    assign inReady = (count_r != 2'h2);
    assign outValid = (count_r != 2'h0);
    assign outData = mem[rdPtr_r];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end else if (ce) begin
            if (doWr) begin
                mem[wrPtr_r] <= inData;
                wrPtr_r <= ~wrPtr_r;
            end
            if (doRd) begin
                rdPtr_r <= ~rdPtr_r;
            end
            if (doWr && !doRd) begin
                count_r <= count_r + 2'h1;
            end else if (doRd && !doWr) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/pscl_loader.v
// Passive serial / fast parallel configuration loader target logic
`timescale 1ns/1ps
`default_nettype none
`include "pscl_consts.vh"

module pscl_loader #(
    parameter [`PSCL_BIT_CNT_W-1:0] STREAM_BITS = 32'h00000400,
    parameter [`PSCL_ADDR_W-1:0] BOOT_ADDR = `PSCL_BOOT_ADDR
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire configClockPin,
    input wire [7:0] dataPin,
    input wire chipEnableInN,
    input wire reconfigRequestN,
    input wire [1:0] schemeSelectPins,
    input wire bootAddrLoad,
    input wire [`PSCL_ADDR_W-1:0] bootAddrValue,
    input wire healthIn,
    output reg healthOut,
    output reg healthOeN,
    output reg loadComplete,
    output reg loadCompleteOeN,
    output reg chainEnableOutN,
    output reg data0OeN,
    output reg [7:0] wordData,
    output reg wordValid,
    input wire wordReady,
    output reg [`PSCL_ADDR_W-1:0] bootAddr,
    output reg stall
);

    reg [2:0] clkSync_r;
    reg [7:0] datS1_r;
    reg [7:0] datS2_r;
    reg [1:0] ceSync_r;
    reg [1:0] cfgSync_r;
    reg [1:0] selSync1_r;
    reg [1:0] selSync2_r;
    reg [1:0] hlthSync_r;
    reg [1:0] state_r;
    reg [1:0] scheme_r;
    reg [2:0] bitIdx_r;
    reg [7:0] shift_r;
    reg [`PSCL_BIT_CNT_W-1:0] bitCnt_r;
    reg pushValid_r;
    reg [7:0] pushData_r;

    wire bufInReady;
    wire bufOutValid;
    wire [7:0] bufOutData;
    wire clkRise;
    wire enabled;
    wire isPar;
    wire [`PSCL_BIT_CNT_W-1:0] step;
    wire [7:0] shiftNxt;
    wire takeEdge;
    wire [`PSCL_BIT_CNT_W-1:0] cntNxt;

    // Rising edge of the synchronised link clock
    assign clkRise = clkSync_r[1] && !clkSync_r[2];
    // Chip enabled and no reconfig request
    assign enabled = !ceSync_r[1] && cfgSync_r[1];
    assign isPar = (scheme_r == `PSCL_SCHEME_FPP);
    assign step = isPar ? 32'h00000008 : 32'h00000001;
    // Serial bits arrive LSB first
    assign shiftNxt = {datS2_r[0], shift_r[7:1]};
    // RL1 RL3 RL13 enabled unstalled edges
    assign takeEdge = enabled && clkRise && !(pushValid_r && !bufInReady);
    assign cntNxt = bitCnt_r + step;

    // Absorbs receiver stalls without losing words
    pscl_buf2 #(.WIDTH(8)) uBuf (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .inValid(pushValid_r),
        .inReady(bufInReady),
        .inData(pushData_r),
        .outValid(bufOutValid),
        .outReady(wordReady || !wordValid),
        .outData(bufOutData)
    );

    // Two flip-flops on every pin before use
    always @(posedge clk) begin
        if (rst) begin
            // Pins read as idle in reset
            clkSync_r <= 3'h0;
            datS1_r <= 8'h00;
            datS2_r <= 8'h00;
            ceSync_r <= 2'h3;
            cfgSync_r <= 2'h0;
            selSync1_r <= 2'h0;
            selSync2_r <= 2'h0;
            hlthSync_r <= 2'h3;
        end else if (ce) begin
            clkSync_r <= {clkSync_r[1:0], configClockPin};
            datS1_r <= dataPin;
            datS2_r <= datS1_r;
            ceSync_r <= {ceSync_r[0], chipEnableInN};
            cfgSync_r <= {cfgSync_r[0], reconfigRequestN};
            selSync1_r <= schemeSelectPins;
            selSync2_r <= selSync1_r;
            hlthSync_r <= {hlthSync_r[0], healthIn};
        end
    end

    // Sequencer, capture and output registers
    always @(posedge clk) begin
        if (rst) begin
            state_r <= `PSCL_ST_IDLE;
            scheme_r <= `PSCL_SCHEME_PS;
            bitIdx_r <= 3'h0;
            shift_r <= 8'h00;
            bitCnt_r <= 32'h00000000;
            pushValid_r <= 1'b0;
            pushData_r <= 8'h00;
            loadComplete <= 1'b0;
            loadCompleteOeN <= 1'b0;
            chainEnableOutN <= 1'b1;
            data0OeN <= 1'b1;
            healthOut <= 1'b0;
            healthOeN <= 1'b0;
            bootAddr <= BOOT_ADDR;
            wordData <= 8'h00;
            wordValid <= 1'b0;
            stall <= 1'b0;
        end else if (ce) begin
            // Output stage refilled from the buffer
            if (bufOutValid && (wordReady || !wordValid)) begin
                wordData <= bufOutData;
                wordValid <= 1'b1;
            end else if (wordReady) begin
                wordValid <= 1'b0;
            end

            if (pushValid_r && bufInReady) begin
                pushValid_r <= 1'b0;
            end
            // Flag a word held back by a full buffer; edges are ignored meanwhile
            stall <= pushValid_r && !bufInReady;

            // RL12 boot address override
            if (bootAddrLoad) begin
                bootAddr <= bootAddrValue;
            end

            // RL14 reconfig clears completion
            if (!cfgSync_r[1]) begin
                state_r <= `PSCL_ST_IDLE;
                // Scheme is latched while reconfig is held
                scheme_r <= selSync2_r;
                bitIdx_r <= 3'h0;
                bitCnt_r <= 32'h00000000;
                loadComplete <= 1'b0;
                loadCompleteOeN <= 1'b0;
                chainEnableOutN <= 1'b1;
                data0OeN <= 1'b1;
                healthOut <= 1'b0;
                healthOeN <= 1'b0;
            end else begin
                case (state_r)
                    `PSCL_ST_IDLE: begin
                        healthOeN <= 1'b1;
                        // RL10 start as soon as enabled, without waiting for an edge
                        if (enabled) begin
                            state_r <= `PSCL_ST_LOAD;
                        end
                    end

                    `PSCL_ST_LOAD: begin
                        // Health low aborts the load
                        if (!hlthSync_r[1]) begin
                            state_r <= `PSCL_ST_ERR;
                        end else if (takeEdge) begin
                            if (isPar) begin
                                // RL15 byte per edge
                                pushData_r <= datS2_r;
                                pushValid_r <= 1'b1;
                            end else begin
                                shift_r <= shiftNxt;
                                bitIdx_r <= bitIdx_r + 3'h1;
                                if (bitIdx_r == 3'h7) begin
                                    pushData_r <= shiftNxt;
                                    pushValid_r <= 1'b1;
                                end
                            end
                            bitCnt_r <= cntNxt;
                            // RL14 last bit ends the load
                            if (cntNxt >= STREAM_BITS) begin
                                state_r <= `PSCL_ST_DONE;
                            end
                        end
                    end

                    `PSCL_ST_DONE: begin
                        // RL14 release completion
                        loadComplete <= 1'b1;
                        loadCompleteOeN <= 1'b1;
                        // RL9 enable next device
                        chainEnableOutN <= 1'b0;
                        // RL8 data pin released as user I/O
                        data0OeN <= 1'b1;
                    end

                    `PSCL_ST_ERR: begin
                        // Drive health low until reconfig
                        healthOut <= 1'b0;
                        healthOeN <= 1'b0;
                    end

                    default: begin
                        state_r <= `PSCL_ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: sim/pscl_host.sv
// Host model driving config clock and data
`timescale 1ns/1ps
`default_nettype none
module pscl_host (
    output var logic cfgClk,
    output var logic [7:0] cfgData
);
    initial begin
        cfgClk = 1'b0;
        cfgData = 8'h00;
    end
    task automatic send(input logic [7:0] v, input logic fast_passive_parallel);
        int i;
        for (i = 0; i < (fast_passive_parallel ? 1 : 8); i++) begin
            cfgData <= fast_passive_parallel ? v : {7'h00, v[i]};
            #80 cfgClk <= 1'b1;
            #80 cfgClk <= 1'b0;
        end
        // inverted last value, not a fixed level
        cfgData <= ~cfgData;
        #20;
    endtask
endmodule
`default_nettype wire

// file: sim/pscl_loader_sva.sv
// Port assertions for the loader
`timescale 1ns/1ps
`default_nettype none
`include "pscl_consts.vh"
module pscl_loader_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reconfigRequestN,
    input wire logic bootAddrLoad,
    input wire logic [`PSCL_ADDR_W-1:0] bootAddrValue,
    input wire logic loadComplete,
    input wire logic loadCompleteOeN,
    input wire logic chainEnableOutN,
    input wire logic data0OeN,
    input wire logic [7:0] wordData,
    input wire logic wordValid,
    input wire logic wordReady,
    input wire logic [`PSCL_ADDR_W-1:0] bootAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence sReq;
        (!reconfigRequestN && ce) [*4];
    endsequence
    sequence sHeld;
        wordValid && !wordReady && ce;
    endsequence
    a_data0_released: assert property (data0OeN) else $error("data0 driven");
    a_chain_follows: assert property (chainEnableOutN == !loadComplete) else $error("chain out");
    a_pin_release: assert property (loadCompleteOeN == loadComplete) else $error("done pin");
    a_boot_load: assert property (bootAddrLoad && ce |=> bootAddr == $past(bootAddrValue)) else $error("boot");
    a_boot_hold: assert property (!bootAddrLoad |=> $stable(bootAddr)) else $error("boot moved");
    a_reconfig_clear: assert property (sReq |=> !loadComplete) else $error("done kept");
    a_done_sticky: assert property (loadComplete && reconfigRequestN |=> loadComplete) else $error("done lost");
    a_word_hold: assert property (sHeld |=> wordValid && $stable(wordData)) else $error("word lost");
endmodule
bind pscl_loader pscl_loader_sva u_sva (.*);
`default_nettype wire

// file: sim/pscl_loader_tb.sv
// Self-checking bench for the loader
`timescale 1ns/1ps
`default_nettype none
`include "pscl_consts.vh"
module pscl_loader_tb;
    logic clk, rst, reconfigRequestN, chipEnableInN, bootAddrLoad, wordReady, healthIn;
    logic [1:0] schemeSelectPins;
    logic [23:0] bootAddrValue;
    wire logic cfgClk, loadComplete, chainEnableOutN, data0OeN, wordValid, healthOut, healthOeN, stall;
    wire logic [7:0] cfgData, wordData;
    wire logic [23:0] bootAddr;
    logic [7:0] q[$];
    int err_total, checks, cyc;
    pscl_loader #(.STREAM_BITS(32'h00000020)) u_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .configClockPin(cfgClk), .dataPin(cfgData),
        .chipEnableInN(chipEnableInN), .reconfigRequestN(reconfigRequestN),
        .schemeSelectPins(schemeSelectPins), .bootAddrLoad(bootAddrLoad), .bootAddrValue(bootAddrValue),
        .healthIn(healthIn), .healthOut(healthOut), .healthOeN(healthOeN), .loadComplete(loadComplete),
        .loadCompleteOeN(),
        .chainEnableOutN(chainEnableOutN), .data0OeN(data0OeN), .wordData(wordData),
        .wordValid(wordValid), .wordReady(wordReady), .bootAddr(bootAddr), .stall(stall));
    pscl_host u_host (.cfgClk(cfgClk), .cfgData(cfgData));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (wordValid === 1'b1 && wordReady === 1'b1) q.push_back(wordData);
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic words(input int n);
        int k;
        for (k = 0; k < 3000 && q.size() < n; k++) @(posedge clk);
        chk(24'(q.size()), 24'(n));
    endtask
    task automatic t_ps;
        logic [7:0] e[4];
        e = '{8'h3C, 8'hC3, 8'h96, 8'h0F};
        chk({loadComplete, chainEnableOutN, data0OeN}, 3'b011);
        chk(bootAddr, `PSCL_BOOT_ADDR);
        u_host.send(8'hA5, 1'b0);
        cycles(20);
        chk(wordValid, 1'b0);
        chipEnableInN <= 1'b0;
        cycles(1);
        u_host.send(e[0], 1'b0);
        #5000;
        u_host.send(e[1], 1'b0);
        cycles(20);
        chk(wordValid, 1'b1);
        wordReady <= 1'b1;
        u_host.send(e[2], 1'b0);
        cycles(10);
        chk(loadComplete, 1'b0);
        u_host.send(e[3], 1'b0);
        words(4);
        foreach (e[i]) chk(q.pop_front(), e[i]);
        cycles(10);
        chk({loadComplete, chainEnableOutN}, 2'b10);
    endtask
    task automatic t_boot;
        bootAddrValue <= 24'hABCDE1;
        bootAddrLoad <= 1'b1;
        cycles(1);
        bootAddrLoad <= 1'b0;
        cycles(2);
        chk(bootAddr, 24'hABCDE1);
    endtask
    task automatic t_fpp;
        reconfigRequestN <= 1'b0;
        schemeSelectPins <= `PSCL_SCHEME_FPP;
        cycles(6);
        chk({loadComplete, chainEnableOutN}, 2'b01);
        reconfigRequestN <= 1'b1;
        cycles(6);
        u_host.send(8'h5A, 1'b1);
        u_host.send(8'hE7, 1'b1);
        words(2);
        chk(q.pop_front(), 8'h5A);
        chk(q.pop_front(), 8'hE7);
    endtask
    task automatic t_stall;
        logic [7:0] e[4];
        e = '{8'h11, 8'h22, 8'h33, 8'h44};
        reconfigRequestN <= 1'b0;
        wordReady <= 1'b0;
        cycles(6);
        reconfigRequestN <= 1'b1;
        cycles(6);
        foreach (e[i]) u_host.send(e[i], 1'b1);
        cycles(10);
        chk({stall, loadComplete}, 2'b11);
        wordReady <= 1'b1;
        words(4);
        foreach (e[i]) chk(q.pop_front(), e[i]);
    endtask
    task automatic t_health;
        reconfigRequestN <= 1'b0;
        cycles(6);
        reconfigRequestN <= 1'b1;
        cycles(6);
        healthIn <= 1'b0;
        cycles(6);
        chk({healthOut, healthOeN}, 2'b00);
        repeat (4) u_host.send(8'h99, 1'b1);
        cycles(10);
        chk({wordValid, loadComplete, chainEnableOutN}, 3'b001);
        if (loadComplete !== 1'b1) reconfigRequestN <= 1'b0;
        healthIn <= 1'b1;
        cycles(6);
        reconfigRequestN <= 1'b1;
        cycles(6);
        chk({healthOut, healthOeN, loadComplete}, 3'b010);
    endtask
    task automatic summarize;
        $display("errors=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        reconfigRequestN = 1'b0;
        chipEnableInN = 1'b1;
        bootAddrLoad = 1'b0;
        bootAddrValue = 24'h000000;
        wordReady = 1'b0;
        healthIn = 1'b1;
        schemeSelectPins = `PSCL_SCHEME_PS;
        err_total = 0;
        checks = 0;
        cyc = 0;
        cycles(3);
        rst <= 1'b0;
        cycles(5);
        reconfigRequestN <= 1'b1;
        cycles(6);
        t_ps();
        t_boot();
        t_fpp();
        t_stall();
        t_health();
        summarize();
    end
endmodule
`default_nettype wire
